// ---- hw/bfle_pkg.sv ----
package bfle_pkg;

  // --------------------------------------------------------------------
  // Bus widths and register map
  // --------------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] OFF_INSTR    = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_FLAGS    = 12'h008;
  localparam logic [11:0] OFF_PC       = 12'h00C;
  localparam logic [11:0] BASE_GPR     = 12'h080;
  localparam logic [11:0] BASE_IO      = 12'h100;
  localparam logic [11:0] BASE_DMEM    = 12'h400;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // --------------------------------------------------------------------
  // Reset values and storage sizes
  // --------------------------------------------------------------------
  localparam logic [7:0]  RST_FLAGS    = 8'h00;
  localparam logic [15:0] RST_PC       = 16'h0000;
  localparam logic [31:0] RST_INSTR    = 32'h00000000;
  localparam int          NUM_GPR      = 32;
  localparam int          NUM_IO       = 64;
  localparam int          NUM_DMEM     = 256;

  // --------------------------------------------------------------------
  // Status flag positions
  // --------------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // --------------------------------------------------------------------
  // Pointer pairs and cycle counts
  // --------------------------------------------------------------------
  localparam logic [4:0] PTR_X_LO   = 5'h1A;
  localparam logic [4:0] PTR_Y_LO   = 5'h1C;
  localparam logic [1:0] CYC_ONE    = 2'h1;
  localparam logic [1:0] CYC_TWO    = 2'h2;

  // --------------------------------------------------------------------
  // Operation codes
  // --------------------------------------------------------------------
  localparam logic [7:0] OP_NOP                  = 8'h00;
  localparam logic [7:0] OP_BRANCH_IRQ_ON        = 8'h01;
  localparam logic [7:0] OP_BRANCH_IRQ_OFF       = 8'h02;
  localparam logic [7:0] OP_IO_BIT_SET           = 8'h03;
  localparam logic [7:0] OP_IO_BIT_CLEAR         = 8'h04;
  localparam logic [7:0] OP_SHIFT_LEFT_LOGICAL   = 8'h05;
  localparam logic [7:0] OP_SHIFT_RIGHT_LOGICAL  = 8'h06;
  localparam logic [7:0] OP_ROTATE_LEFT_CARRY    = 8'h07;
  localparam logic [7:0] OP_ROTATE_RIGHT_CARRY   = 8'h08;
  localparam logic [7:0] OP_SHIFT_RIGHT_ARITH    = 8'h09;
  localparam logic [7:0] OP_NIBBLE_SWAP          = 8'h0A;
  localparam logic [7:0] OP_STATUS_FLAG_SET      = 8'h0B;
  localparam logic [7:0] OP_STATUS_FLAG_CLEAR    = 8'h0C;
  localparam logic [7:0] OP_BIT_TO_TRANSFER_FLAG = 8'h0D;
  localparam logic [7:0] OP_TRANSFER_FLAG_TO_BIT = 8'h0E;
  localparam logic [7:0] OP_MOVE                 = 8'h10;
  localparam logic [7:0] OP_WORD_PAIR_COPY       = 8'h11;
  localparam logic [7:0] OP_LOAD_IMMEDIATE       = 8'h12;
  // Dedicated flag ops: base | flag << 1 | set.
  localparam logic [3:0] OP_ONE_FLAG_HI          = 4'h2;
  // Indirect loads: base | pointer << 2 | mode.
  localparam logic [4:0] OP_LOAD_INDIRECT_HI     = 5'h06;
  localparam logic [1:0] LOAD_MODE_PLAIN         = 2'h0;
  localparam logic [1:0] LOAD_MODE_POST_INC      = 2'h1;
  localparam logic [1:0] LOAD_MODE_PRE_DEC       = 2'h2;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EX1  = 2'b01,
    ST_EX2  = 2'b10
  } bfle_state_t;

  typedef enum logic [2:0] {
    RG_INSTR  = 3'b000,
    RG_STATUS = 3'b001,
    RG_FLAGS  = 3'b010,
    RG_PC     = 3'b011,
    RG_GPR    = 3'b100,
    RG_IO     = 3'b101,
    RG_DMEM   = 3'b110,
    RG_NONE   = 3'b111
  } bfle_region_t;

  typedef struct packed {
    logic [7:0] imm;
    logic [1:0] rsvd_hi;
    logic [5:0] src;
    logic [2:0] rsvd_lo;
    logic [4:0] rd;
    logic [7:0] op;
  } bfle_instr_t;

  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } bfle_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } bfle_axi_rsp_t;

  function automatic bfle_region_t bfle_region(input logic [11:0] a);
    if (a[11:2] == OFF_INSTR[11:2]) return RG_INSTR;
    if (a[11:2] == OFF_STATUS[11:2]) return RG_STATUS;
    if (a[11:2] == OFF_FLAGS[11:2]) return RG_FLAGS;
    if (a[11:2] == OFF_PC[11:2]) return RG_PC;
    if (a[11:7] == BASE_GPR[11:7]) return RG_GPR;
    if (a[11:8] == BASE_IO[11:8]) return RG_IO;
    if (a[11:10] == BASE_DMEM[11:10]) return RG_DMEM;
    return RG_NONE;
  endfunction : bfle_region

endpackage : bfle_pkg

// ---- hw/bfle_core.sv ----
// Summary of operation
// RQ1: Interrupt-flag branches add offset plus one when matched; 1/2 cycles.
// RQ2: I/O bit set writes one to the chosen bit; no flags; two cycles.
// RQ3: I/O bit clear writes zero to the chosen bit; no flags; two cycles.
// RQ4: Logical left shift fills bit 0 with zero; updates Z,C,N,V; one cycle.
// RQ5: Logical right shift fills bit 7 with zero; updates Z,C,N,V; one cycle.
// RQ6: Rotate left moves carry in at bit 0, bit 7 to carry.
// RQ7: Rotate right moves carry in at bit 7, bit 0 to carry.
// RQ8: Arithmetic right shift keeps the sign bit; updates Z,C,N,V; one cycle.
// RQ9: Nibble swap exchanges register halves in one cycle; flags untouched.
// RQ10: Generic flag set or clear changes only the selected bit.
// RQ11: Bit store copies a register bit into the transfer flag only.
// RQ12: Bit load copies the transfer flag into a register bit only.
// RQ13: Dedicated ops set or clear each single flag in one cycle.
// RQ14: Indirect loads read memory at the pointer; no flags; two cycles.
// RQ15: Post-increment uses the old pointer, then adds one.
// RQ16: Pre-decrement subtracts one first, then reads at the new address.
// RQ17: Move, word copy and immediate load take one cycle, no flags.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module bfle_core (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire bfle_pkg::bfle_axi_req_t axi_req,
  output wire bfle_pkg::bfle_axi_rsp_t axi_rsp
);
  import bfle_pkg::*;

  // --------------------------------------------------------------------
  // Storage and state
  // --------------------------------------------------------------------
  logic [7:0]   gpr  [0:NUM_GPR-1];
  logic [7:0]   io   [0:NUM_IO-1];
  logic [7:0]   dmem [0:NUM_DMEM-1];
  logic [7:0]   flags;
  logic [15:0]  pc;
  bfle_instr_t  instr;
  bfle_state_t  state;
  logic [1:0]   last_cycles;
  logic [7:0]   dm_addr;

  logic         awready;
  logic         aw_full;
  logic [11:0]  aw_addr;
  logic         wready;
  logic         w_full;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         bvalid;
  logic [1:0]   bresp;
  logic         arready;
  logic         rvalid;
  logic [31:0]  rdata;
  logic [1:0]   rresp;

  bfle_region_t wr_region;
  bfle_region_t rd_region;
  logic         wr_go;
  logic         lane0;
  logic [31:0]  rd_word;

  assign axi_rsp.awready = awready;
  assign axi_rsp.wready  = wready;
  assign axi_rsp.bvalid  = bvalid;
  assign axi_rsp.bresp   = bresp;
  assign axi_rsp.arready = arready;
  assign axi_rsp.rvalid  = rvalid;
  assign axi_rsp.rdata   = rdata;
  assign axi_rsp.rresp   = rresp;

  // --------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------
  assign wr_region = bfle_region(aw_addr);
  assign lane0     = w_strb[0];
  // Writes wait while an instruction runs, so bus and core never collide.
  assign wr_go     = aw_full && w_full && !bvalid && (state == ST_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (axi_req.awvalid && awready) begin
      awready <= 1'b0;
      aw_full <= 1'b1;
      aw_addr <= axi_req.awaddr;
    end else if (bvalid && axi_req.bready) begin
      awready <= 1'b1;
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (axi_req.wvalid && wready) begin
      wready <= 1'b0;
      w_full <= 1'b1;
      w_data <= axi_req.wdata;
      w_strb <= axi_req.wstrb;
    end else if (bvalid && axi_req.bready) begin
      wready <= 1'b1;
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= (wr_region == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid && axi_req.bready) begin
      bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------
  assign rd_region = bfle_region(axi_req.araddr);

  always_comb begin
    rd_word = '0;
    case (rd_region)
      RG_INSTR:  rd_word = instr;
      RG_STATUS: rd_word = {29'h0, last_cycles, (state != ST_IDLE)};
      RG_FLAGS:  rd_word = {24'h0, flags};
      RG_PC:     rd_word = {16'h0, pc};
      RG_GPR:    rd_word = {24'h0, gpr[axi_req.araddr[6:2]]};
      RG_IO:     rd_word = {24'h0, io[axi_req.araddr[7:2]]};
      RG_DMEM:   rd_word = {24'h0, dmem[axi_req.araddr[9:2]]};
      default:   rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (axi_req.arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= (rd_region == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && axi_req.rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Execute: next values for one instruction
  // --------------------------------------------------------------------
  logic [7:0]  opnd;
  logic [7:0]  res;
  logic        res_we;
  logic        shift_op;
  logic        carry_out;
  logic        pair_we;
  logic [4:0]  pair_lo;
  logic [15:0] pair_val;
  logic [7:0]  next_flags;
  logic [15:0] next_pc;
  logic        io_we;
  logic [7:0]  io_val;
  logic        two_cycle;
  logic [15:0] ptr;
  logic [4:0]  ptr_lo;
  logic [7:0]  next_dm_addr;
  logic [2:0]  sel;

  assign opnd = gpr[instr.rd];
  assign sel  = instr.imm[2:0];

  always_comb begin
    res          = opnd;
    res_we       = 1'b0;
    shift_op     = 1'b0;
    carry_out    = 1'b0;
    pair_we      = 1'b0;
    pair_lo      = '0;
    pair_val     = '0;
    next_flags   = flags;
    next_pc      = pc + 16'h0001;
    io_we        = 1'b0;
    io_val       = io[instr.src];
    two_cycle    = 1'b0;
    ptr_lo       = instr.op[2] ? PTR_Y_LO : PTR_X_LO;
    ptr          = {gpr[ptr_lo + 5'h01], gpr[ptr_lo]};
    next_dm_addr = ptr[7:0];
    case (instr.op)
      // RQ1 interrupt-flag branch
      OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF: begin
        if (flags[FLAG_I] == (instr.op == OP_BRANCH_IRQ_ON)) begin
          next_pc   = pc + {{8{instr.imm[7]}}, instr.imm} + 16'h0001;
          two_cycle = 1'b1;
        end
      end
      // RQ2 set I/O bit
      OP_IO_BIT_SET: begin
        io_val[sel] = 1'b1;
        io_we       = 1'b1;
        two_cycle   = 1'b1;
      end
      // RQ3 clear I/O bit
      OP_IO_BIT_CLEAR: begin
        io_val[sel] = 1'b0;
        io_we       = 1'b1;
        two_cycle   = 1'b1;
      end
      // RQ4 logical left shift
      OP_SHIFT_LEFT_LOGICAL: begin
        res       = {opnd[6:0], 1'b0};
        carry_out = opnd[7];
        shift_op  = 1'b1;
      end
      // RQ5 logical right shift
      OP_SHIFT_RIGHT_LOGICAL: begin
        res       = {1'b0, opnd[7:1]};
        carry_out = opnd[0];
        shift_op  = 1'b1;
      end
      // RQ6 rotate left carry
      OP_ROTATE_LEFT_CARRY: begin
        res       = {opnd[6:0], flags[FLAG_C]};
        carry_out = opnd[7];
        shift_op  = 1'b1;
      end
      // RQ7 rotate right carry
      OP_ROTATE_RIGHT_CARRY: begin
        res       = {flags[FLAG_C], opnd[7:1]};
        carry_out = opnd[0];
        shift_op  = 1'b1;
      end
      // RQ8 sign-keeping shift
      OP_SHIFT_RIGHT_ARITH: begin
        res       = {opnd[7], opnd[7:1]};
        carry_out = opnd[0];
        shift_op  = 1'b1;
      end
      // RQ9 nibble exchange
      OP_NIBBLE_SWAP: begin
        res    = {opnd[3:0], opnd[7:4]};
        res_we = 1'b1;
      end
      // RQ10 generic flag set
      OP_STATUS_FLAG_SET: next_flags[sel] = 1'b1;
      // RQ10 generic flag clear
      OP_STATUS_FLAG_CLEAR: next_flags[sel] = 1'b0;
      // RQ11 bit to transfer
      OP_BIT_TO_TRANSFER_FLAG: next_flags[FLAG_T] = opnd[sel];
      // RQ12 transfer to bit
      OP_TRANSFER_FLAG_TO_BIT: begin
        res[sel] = flags[FLAG_T];
        res_we   = 1'b1;
      end
      // RQ17 register move
      OP_MOVE: begin
        res    = gpr[instr.src[4:0]];
        res_we = 1'b1;
      end
      // RQ17 even pair copy
      OP_WORD_PAIR_COPY: begin
        pair_we  = 1'b1;
        pair_lo  = {instr.rd[4:1], 1'b0};
        pair_val = {gpr[{instr.src[4:1], 1'b1}], gpr[{instr.src[4:1], 1'b0}]};
      end
      // RQ17 immediate load
      OP_LOAD_IMMEDIATE: begin
        res    = instr.imm;
        res_we = 1'b1;
      end
      default: begin
        // RQ13 dedicated flag ops
        if (instr.op[7:4] == OP_ONE_FLAG_HI) begin
          next_flags[instr.op[3:1]] = instr.op[0];
        end
        // RQ14 indirect load
        if (instr.op[7:3] == OP_LOAD_INDIRECT_HI) begin
          two_cycle = 1'b1;
          // RQ15 post-increment pointer
          if (instr.op[1:0] == LOAD_MODE_POST_INC) begin
            pair_we  = 1'b1;
            pair_lo  = ptr_lo;
            pair_val = ptr + 16'h0001;
          end
          // RQ16 pre-decrement pointer
          if (instr.op[1:0] == LOAD_MODE_PRE_DEC) begin
            pair_we      = 1'b1;
            pair_lo      = ptr_lo;
            pair_val     = ptr - 16'h0001;
            next_dm_addr = pair_val[7:0];
          end
        end
      end
    endcase
    if (shift_op) begin
      res_we             = 1'b1;
      next_flags[FLAG_C] = carry_out;
      next_flags[FLAG_N] = res[7];
      next_flags[FLAG_Z] = (res == 8'h00);
      next_flags[FLAG_V] = res[7] ^ carry_out;
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= ST_IDLE;
      instr       <= RST_INSTR;
      last_cycles <= '0;
      dm_addr     <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_go && (wr_region == RG_INSTR)) begin
            instr <= w_data;
            state <= ST_EX1;
          end
        end
        ST_EX1: begin
          dm_addr     <= next_dm_addr;
          last_cycles <= two_cycle ? CYC_TWO : CYC_ONE;
          state       <= two_cycle ? ST_EX2 : ST_IDLE;
        end
        ST_EX2:  state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= RST_FLAGS;
      pc    <= RST_PC;
    end else if (state == ST_EX1) begin
      flags <= next_flags;
      pc    <= next_pc;
    end else if (wr_go && lane0 && (wr_region == RG_FLAGS)) begin
      flags <= w_data[7:0];
    end else if (wr_go && (wr_region == RG_PC)) begin
      if (w_strb[0]) pc[7:0] <= w_data[7:0];
      if (w_strb[1]) pc[15:8] <= w_data[15:8];
    end
  end

  // --------------------------------------------------------------------
  // Register file and memories
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (state == ST_EX1 && res_we) begin
      gpr[instr.rd] <= res;
    end
    if (state == ST_EX1 && pair_we) begin
      gpr[pair_lo]          <= pair_val[7:0];
      gpr[pair_lo + 5'h01]  <= pair_val[15:8];
    end
    // RQ14 data into destination
    if (state == ST_EX2 && instr.op[7:3] == OP_LOAD_INDIRECT_HI) begin
      gpr[instr.rd] <= dmem[dm_addr];
    end
    if (wr_go && lane0 && (wr_region == RG_GPR)) begin
      gpr[aw_addr[6:2]] <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (state == ST_EX1 && io_we) begin
      io[instr.src] <= io_val;
    end
    if (wr_go && lane0 && (wr_region == RG_IO)) begin
      io[aw_addr[7:2]] <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_go && lane0 && (wr_region == RG_DMEM)) begin
      dmem[aw_addr[9:2]] <= w_data[7:0];
    end
  end

endmodule : bfle_core

// ---- sim/bfle_core_monitor.sv ----
`timescale 1ns/1ns
module bfle_core_monitor (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire bfle_pkg::bfle_axi_req_t axi_req,
  input wire bfle_pkg::bfle_axi_rsp_t axi_rsp
);
  import bfle_pkg::*;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read address not answered on the next cycle");
  a_read_hold: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
    else $error("read data dropped or changed before rready");
  a_read_done: assert property (axi_rsp.rvalid && axi_req.rready
    |=> !axi_rsp.rvalid && axi_rsp.arready)
    else $error("read channel did not reopen after rready");
  a_ar_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("arready high while read data pending");
  a_err_data: assert property (axi_rsp.rvalid
    && axi_rsp.rresp == RESP_SLVERR |-> axi_rsp.rdata == 32'h0)
    else $error("refused read returned nonzero data");

  // ------------------------------------------------------------------
  // Write channel
  // ------------------------------------------------------------------
  a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready
    && axi_req.wvalid && axi_rsp.wready |-> ##[1:4] axi_rsp.bvalid)
    else $error("write response late");
  a_write_hold: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped before bready");
  a_write_done: assert property (axi_rsp.bvalid && axi_req.bready
    |=> !axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready)
    else $error("write channel did not reopen after bready");
  a_aw_blocked: assert property (axi_rsp.bvalid
    |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write channel open while response pending");

  c_read: cover property (axi_rsp.rvalid && axi_req.rready);
  c_write: cover property (axi_rsp.bvalid && axi_req.bready);
  c_refused: cover property (axi_rsp.rvalid
    && axi_rsp.rresp == RESP_SLVERR);
endmodule : bfle_core_monitor

bind bfle_core bfle_core_monitor u_mon (
  .aclk    (aclk),
  .aresetn (aresetn),
  .axi_req (axi_req),
  .axi_rsp (axi_rsp)
);

// ---- sim/bit_flag_and_load_execute_tb.sv ----
`timescale 1ns/1ns
module bit_flag_and_load_execute_tb;
  import bfle_pkg::*;

  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  bfle_axi_req_t req = '0;
  bfle_axi_rsp_t rsp;
  int            err_total = 0;
  int            samples_checked = 0;
  logic [31:0]   rd_v;
  logic [1:0]    rs_v;
  logic [15:0]   e;
  logic [15:0]   pt;
  logic [7:0]    vv [2] = '{8'h81, 8'h01};
  logic [7:0]    sv [2] = '{8'hF1, 8'h0E};
  logic [7:0]    m8;
  logic [4:0]    lo;

  always #25 aclk = ~aclk;

  bfle_core u_dut (
    .aclk    (aclk),
    .aresetn (aresetn),
    .axi_req (req),
    .axi_rsp (rsp)
  );

  // ------------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------------
  task automatic end_of_test;
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    rs_v = rsp.bresp;
  endtask : axw

  task automatic axr(input logic [11:0] a);
    logic ar;
    ar = 1'b1;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar && rsp.arready === 1'b1) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    rd_v = rsp.rdata;
    rs_v = rsp.rresp;
  endtask : axr

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] x);
    axr(a);
    chk(nm, rd_v, x);
  endtask : rchk

  function automatic logic [11:0] ad(input logic [11:0] b,
                                     input logic [7:0] n);
    return b + {2'b00, n, 2'b00};
  endfunction : ad

  // Launches one instruction, waits until idle, checks its cycle count.
  task automatic exec(input logic [7:0] op, input logic [4:0] d,
                      input logic [5:0] s, input logic [7:0] imm,
                      input logic [1:0] cyc);
    axw(OFF_INSTR, {imm, 2'b00, s, 3'b000, d, op});
    do axr(OFF_STATUS); while (rd_v[0] !== 1'b0);
    chk("cycles", 32'(rd_v[2:1]), 32'(cyc));
  endtask : exec

  // Expected {flags, result} of a shift, rotate or nibble swap.
  function automatic logic [15:0] shx(input logic [7:0] op,
                                      input logic [7:0] v,
                                      input logic [7:0] s);
    logic [7:0] r;
    logic       c;
    c = s[FLAG_C];
    r = v;
    case (op)
      OP_SHIFT_LEFT_LOGICAL: {c, r} = {v, 1'b0};
      OP_SHIFT_RIGHT_LOGICAL: {r, c} = {1'b0, v};
      OP_ROTATE_LEFT_CARRY: {c, r} = {v, s[FLAG_C]};
      OP_ROTATE_RIGHT_CARRY: {r, c} = {s[FLAG_C], v};
      OP_SHIFT_RIGHT_ARITH: {r, c} = {v[7], v};
      default: return {s, v[3:0], v[7:4]};
    endcase
    s[FLAG_C] = c;
    s[FLAG_Z] = (r == 8'h00);
    s[FLAG_N] = r[7];
    s[FLAG_V] = r[7] ^ c;
    return {s, r};
  endfunction : shx

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("flags_rst", OFF_FLAGS, 32'(RST_FLAGS));
    chk("okay_rresp", 32'(rs_v), 32'(RESP_OKAY));
    rchk("pc_rst", OFF_PC, 32'(RST_PC));
    rchk("instr_rst", OFF_INSTR, RST_INSTR);
    rchk("unmapped_rd", 12'h010, 32'h0);
    chk("unmapped_rresp", 32'(rs_v), 32'(RESP_SLVERR));
    axw(12'h200, 32'h0000_00FF);
    chk("unmapped_bresp", 32'(rs_v), 32'(RESP_SLVERR));
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 2; j++) begin
        axw(ad(BASE_GPR, 8'h05), 32'(vv[j]));
        axw(OFF_FLAGS, 32'(sv[j]));
        e = shx(8'h05 + 8'(i), vv[j], sv[j]);
        exec(8'h05 + 8'(i), 5'h05, 6'h00, 8'h00, CYC_ONE);
        rchk("shift_res", ad(BASE_GPR, 8'h05), 32'(e[7:0]));
        rchk("shift_flags", OFF_FLAGS, 32'(e[15:8]));
      end
    end
    for (int k = 0; k < 8; k++) begin
      for (int s = 0; s < 2; s++) begin
        m8 = s[0] ? (8'h01 << k) : ~(8'h01 << k);
        axw(OFF_FLAGS, s[0] ? 32'h00 : 32'hFF);
        exec(s[0] ? OP_STATUS_FLAG_SET : OP_STATUS_FLAG_CLEAR, 5'h00,
             6'h00, 8'(k), CYC_ONE);
        rchk("flag_generic", OFF_FLAGS, 32'(m8));
        axw(OFF_FLAGS, s[0] ? 32'h00 : 32'hFF);
        exec({OP_ONE_FLAG_HI, k[2:0], s[0]}, 5'h00, 6'h00, 8'h00,
             CYC_ONE);
        rchk("flag_single", OFF_FLAGS, 32'(m8));
      end
    end
    axw(OFF_FLAGS, 32'h00);
    axw(ad(BASE_GPR, 8'h03), 32'h04);
    exec(OP_BIT_TO_TRANSFER_FLAG, 5'h03, 6'h00, 8'h02, CYC_ONE);
    rchk("t_from_bit", OFF_FLAGS, 32'h40);
    axw(ad(BASE_GPR, 8'h04), 32'h00);
    exec(OP_TRANSFER_FLAG_TO_BIT, 5'h04, 6'h00, 8'h07, CYC_ONE);
    rchk("bit_from_t", ad(BASE_GPR, 8'h04), 32'h80);
    rchk("bit_from_t_fl", OFF_FLAGS, 32'h40);
    axw(OFF_FLAGS, 32'hA5);
    chk("okay_bresp", 32'(rs_v), 32'(RESP_OKAY));
    axw(ad(BASE_IO, 8'h05), 32'h5A);
    exec(OP_IO_BIT_SET, 5'h00, 6'h05, 8'h00, CYC_TWO);
    rchk("io_set", ad(BASE_IO, 8'h05), 32'h5B);
    exec(OP_IO_BIT_CLEAR, 5'h00, 6'h05, 8'h06, CYC_TWO);
    rchk("io_clear", ad(BASE_IO, 8'h05), 32'h1B);
    rchk("io_flags", OFF_FLAGS, 32'hA5);
    for (int i = 0; i < 4; i++) begin
      axw(OFF_FLAGS, {24'h0, i[0], 7'h00});
      axw(OFF_PC, 32'h0010);
      exec(i[1] ? OP_BRANCH_IRQ_OFF : OP_BRANCH_IRQ_ON, 5'h00, 6'h00,
           8'hFE, (i[1] ^ i[0]) ? CYC_TWO : CYC_ONE);
      rchk("branch_pc", OFF_PC, (i[1] ^ i[0]) ? 32'h0F : 32'h11);
      rchk("branch_fl", OFF_FLAGS, {24'h0, i[0], 7'h00});
    end
    axw(ad(BASE_DMEM, 8'h00), 32'h11);
    axw(ad(BASE_DMEM, 8'hFF), 32'hEE);
    axw(OFF_FLAGS, 32'h5A);
    for (int p = 0; p < 2; p++) begin
      lo = p[0] ? PTR_Y_LO : PTR_X_LO;
      pt = 16'h0100;
      axw(ad(BASE_GPR, 8'(lo)), 32'h00);
      axw(ad(BASE_GPR, 8'(lo) + 8'h01), 32'h01);
      for (int m = 2; m >= 0; m--) begin
        if (m == 2) pt = pt - 16'h0001;
        e = {8'h00, pt[7:0] ^ 8'h11};
        if (m == 1) pt = pt + 16'h0001;
        exec({OP_LOAD_INDIRECT_HI, p[0], m[1:0]}, 5'h01, 6'h00, 8'h00,
             CYC_TWO);
        rchk("load_data", ad(BASE_GPR, 8'h01), 32'(e));
        rchk("ptr_lo", ad(BASE_GPR, 8'(lo)), 32'(pt[7:0]));
        rchk("ptr_hi", ad(BASE_GPR, 8'(lo) + 8'h01), 32'(pt[15:8]));
      end
    end
    rchk("load_flags", OFF_FLAGS, 32'h5A);
    exec(OP_LOAD_IMMEDIATE, 5'h10, 6'h00, 8'h9C, CYC_ONE);
    rchk("load_imm", ad(BASE_GPR, 8'h10), 32'h9C);
    exec(OP_MOVE, 5'h11, 6'h10, 8'h00, CYC_ONE);
    rchk("mov", ad(BASE_GPR, 8'h11), 32'h9C);
    axw(ad(BASE_GPR, 8'h14), 32'h12);
    axw(ad(BASE_GPR, 8'h15), 32'h34);
    exec(OP_WORD_PAIR_COPY, 5'h09, 6'h15, 8'h00, CYC_ONE);
    rchk("pair_lo", ad(BASE_GPR, 8'h08), 32'h12);
    rchk("pair_hi", ad(BASE_GPR, 8'h09), 32'h34);
    rchk("move_flags", OFF_FLAGS, 32'h5A);
    end_of_test();
  end

  // Cuts a hang short well after the sequence should have finished.
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    end_of_test();
  end
endmodule : bit_flag_and_load_execute_tb
